// ===== include/buzzer_defines.svh
// Purpose: offsets, field positions, reset values for the buzzer tone generator
// Assumes: APB, 32-bit data, one aligned word per register
// Notes:   definitions only
`ifndef BUZZER_DEFINES_SVH
`define BUZZER_DEFINES_SVH
`define OFS_TONE_CLOCK_CONFIG 12'h000
`define OFS_TONE_CONTROL      12'h004
`define OFS_TONE_SELECT       12'h008
`define OFS_SOUND_BUFFER      12'h00c
`define OFS_TONE_FLAGS        12'h010
`define OFS_TONE_IRQ_ENABLE   12'h014
`define OFS_SYS_STATE         12'h018
// tone_clock_config fields
`define BIT_DEBUG_RUN         0
`define BIT_SLEEP_CLOCK_STOP  1
`define POS_TONE_DIV          8
// tone_control fields
`define BIT_BLOCK_ENABLE      0
`define BIT_STOP_REQUEST      1
// tone_select fields
`define BIT_DRIVE_MODE        0
`define POS_OUTPUT_MODE       4
// sound_buffer fields
`define POS_PERIOD_COUNT      0
`define POS_HIGH_LENGTH       8
// tone_flags fields
`define BIT_BUFFER_EMPTY      0
`define BIT_OUTPUT_DONE       1
`define BIT_OUTPUT_BUSY       2
// sys_state fields
`define BIT_SLEEP_MODE        0
`define BIT_DEBUG_MODE        1
// reset values
`define RST_TONE_DIV          11'h5f6
`define RST_SLEEP_CLOCK_STOP  1'b1
`define RST_BUFFER_EMPTY      1'b1
`endif

// ===== include/buzzer_pkg.sv
// Purpose: shared types for the buzzer tone generator
// Assumes: nothing
// Notes:   constants live in buzzer_defines.svh
package buzzer_pkg;
	typedef struct packed {
		logic [5:0] high_length;
		logic [7:0] period_count;
	} tone_setting_s;

	typedef enum logic [1:0] {
		mode_normal,
		mode_one_shot,
		mode_melody,
		mode_reserved
	} output_mode_e;

	typedef enum {
		st_idle,
		st_pending,
		st_playing
	} tone_state_e;
endpackage : buzzer_pkg

// ===== hdl/tone_wave.sv
// Purpose: period and duty counter producing the raw tone waveform
// Assumes: tick is one pclk pulse per tone clock cycle
// Notes:   counters held at zero while not running
`timescale 1ns/1ps
module tone_wave
(
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    tick,
	input  wire logic                    run,
	input  wire buzzer_pkg::tone_setting_s setting,
	output logic                         wave
);
	logic [7:0] count;
	logic [7:0] next_count;
	logic       next_wave;

	always_comb
	begin
		next_count = count;
		next_wave  = wave;
		if (!run)
		begin
			next_count = 8'h00;
			next_wave  = 1'b0;
		end
		else if (tick)
		begin
			// period_count+1 ticks per period
			next_count = (count >= setting.period_count) ? 8'h00 : count + 8'h01;
			// high for high_length+1 ticks
			next_wave = (count <= {2'b00, setting.high_length});
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count <= 8'h00;
			wave  <= 1'b0;
		end
		else
		begin
			count <= next_count;
			wave  <= next_wave;
		end
	end
endmodule : tone_wave

// ===== hdl/buzzer_tone_generator.sv
// Purpose: normal-mode buzzer tone generator with APB registers
// Assumes: pclk 50 MHz; sleep and debug states arrive as synchronous inputs
// Notes:   tone clock derived from pclk by a divider (default near 32 kHz)
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "buzzer_defines.svh"
module buzzer_tone_generator
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sleep_mode,
	input  wire logic        debug_mode,
	output logic             tone_out,
	output logic             tone_out_n
);
	logic                        debug_run;
	logic                        sleep_clock_stop;
	logic [10:0]                 tone_div;
	logic                        block_enable;
	logic                        drive_mode_select;
	logic [1:0]                  output_mode_select;
	buzzer_pkg::tone_setting_s   sound_buffer;
	buzzer_pkg::tone_setting_s   sound_reg;
	logic                        buffer_empty_flag;
	logic                        output_done_flag;
	// busy means a tone is loaded; a reload while playing keeps it up
	logic                        output_busy_flag;
	logic [1:0]                  tone_irq_enable;
	buzzer_pkg::tone_state_e     state;
	logic [10:0]                 div_count;
	logic                        tick;
	logic                        wave;
	logic                        next_tone_out;
	logic                        next_tone_out_n;
	logic                        clk_run;
	logic                        wr;
	logic                        rd;
	logic                        stop_wr;
	logic                        buf_wr;
	logic                        mapped;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		hit = (a[11:2] == ofs[11:2]);
	endfunction : hit

	assign wr = psel && penable && pwrite;
	assign rd = psel && !penable && !pwrite;
	assign mapped = hit(paddr, `OFS_TONE_CLOCK_CONFIG) || hit(paddr, `OFS_TONE_CONTROL)
		|| hit(paddr, `OFS_TONE_SELECT) || hit(paddr, `OFS_SOUND_BUFFER)
		|| hit(paddr, `OFS_TONE_FLAGS) || hit(paddr, `OFS_TONE_IRQ_ENABLE)
		|| hit(paddr, `OFS_SYS_STATE);
	assign stop_wr = wr && hit(paddr, `OFS_TONE_CONTROL) && pwdata[`BIT_STOP_REQUEST];
	assign buf_wr = wr && hit(paddr, `OFS_SOUND_BUFFER);
	// tone clock gating; registers stay reachable, only the tone side freezes
	assign clk_run = block_enable
		&& !(sleep_mode && sleep_clock_stop)
		&& !(debug_mode && !debug_run);

	// tone clock divider
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div_count <= 11'h000;
			tick      <= 1'b0;
		end
		else if (clk_run)
		begin
			div_count <= (div_count >= tone_div) ? 11'h000 : div_count + 11'h001;
			tick      <= (div_count >= tone_div);
		end
		else
		begin
			div_count <= div_count;
			tick      <= 1'b0;
		end
	end

	// register writes and flag/state sequencing
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			debug_run          <= 1'b0;
			sleep_clock_stop   <= `RST_SLEEP_CLOCK_STOP;
			tone_div           <= `RST_TONE_DIV;
			block_enable       <= 1'b0;
			drive_mode_select  <= 1'b0;
			output_mode_select <= 2'h0;
			sound_buffer       <= '0;
			sound_reg          <= '0;
			buffer_empty_flag  <= `RST_BUFFER_EMPTY;
			output_done_flag   <= 1'b0;
			tone_irq_enable    <= 2'h0;
			output_busy_flag   <= 1'b0;
			state              <= buzzer_pkg::st_idle;
		end
		else
		begin
			if (wr && hit(paddr, `OFS_TONE_CLOCK_CONFIG))
			begin
				debug_run        <= pwdata[`BIT_DEBUG_RUN];
				sleep_clock_stop <= pwdata[`BIT_SLEEP_CLOCK_STOP];
				tone_div         <= pwdata[`POS_TONE_DIV +: 11];
			end
			if (wr && hit(paddr, `OFS_TONE_CONTROL))
				block_enable <= pwdata[`BIT_BLOCK_ENABLE];
			if (wr && hit(paddr, `OFS_TONE_SELECT))
			begin
				drive_mode_select  <= pwdata[`BIT_DRIVE_MODE];
				output_mode_select <= pwdata[`POS_OUTPUT_MODE +: 2];
			end
			if (wr && hit(paddr, `OFS_TONE_IRQ_ENABLE))
				tone_irq_enable <= pwdata[1:0];
			if (buf_wr)
				sound_buffer <= {pwdata[`POS_HIGH_LENGTH +: 6], pwdata[`POS_PERIOD_COUNT +: 8]};
			// write-one clears; a set in the same cycle wins below
			if (wr && hit(paddr, `OFS_TONE_FLAGS))
			begin
				if (pwdata[`BIT_BUFFER_EMPTY])
					buffer_empty_flag <= 1'b0;
				if (pwdata[`BIT_OUTPUT_DONE])
					output_done_flag <= 1'b0;
			end
			case (state)
				buzzer_pkg::st_idle,
				buzzer_pkg::st_playing:
				begin
					if (buf_wr)
					begin
						buffer_empty_flag <= 1'b0;
						state             <= buzzer_pkg::st_pending;
					end
				end
				buzzer_pkg::st_pending:
				begin
					if (tick && !buf_wr)
					begin
						sound_reg         <= sound_buffer;
						buffer_empty_flag <= 1'b1;
						output_busy_flag  <= 1'b1;
						state             <= buzzer_pkg::st_playing;
					end
				end
				default:
					state <= buzzer_pkg::st_idle;
			endcase
			if (stop_wr && state != buzzer_pkg::st_idle)
			begin
				state            <= buzzer_pkg::st_idle;
				output_done_flag <= 1'b1;
				output_busy_flag <= 1'b0;
			end
			if (!block_enable)
			begin
				state            <= buzzer_pkg::st_idle;
				output_busy_flag <= 1'b0;
			end
		end
	end

	tone_wave u_wave
	(
		.pclk    (pclk),
		.presetn (presetn),
		.tick    (tick),
		.run     (output_busy_flag),
		.setting (sound_reg),
		.wave    (wave)
	);

	// pin drive; frozen while the tone clock is stopped by sleep or debug, still driven while block_enable is low
	always_comb
	begin
		next_tone_out   = tone_out;
		next_tone_out_n = tone_out_n;
		if (clk_run || !block_enable)
		begin
			next_tone_out = wave && output_busy_flag;
			if (drive_mode_select)
				next_tone_out_n = !next_tone_out;
			else if (output_busy_flag)
				next_tone_out_n = !next_tone_out;
			else
				next_tone_out_n = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tone_out   <= 1'b0;
			tone_out_n <= 1'b0;
		end
		else
		begin
			tone_out   <= next_tone_out;
			tone_out_n <= next_tone_out_n;
		end
	end

	// apb: zero-wait, read data registered in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			if (rd)
			begin
				prdata <= 32'h0000_0000;
				if (hit(paddr, `OFS_TONE_CLOCK_CONFIG))
					prdata <= {13'h0000, tone_div, 6'h00, sleep_clock_stop, debug_run};
				else if (hit(paddr, `OFS_TONE_CONTROL))
					prdata <= {31'h0000_0000, block_enable};
				else if (hit(paddr, `OFS_TONE_SELECT))
					prdata <= {26'h000_0000, output_mode_select, 3'h0, drive_mode_select};
				else if (hit(paddr, `OFS_SOUND_BUFFER))
					prdata <= {18'h0_0000, sound_buffer.high_length, sound_buffer.period_count};
				else if (hit(paddr, `OFS_TONE_FLAGS))
					prdata <= {29'h0000_0000, output_busy_flag,
						output_done_flag, buffer_empty_flag};
				else if (hit(paddr, `OFS_TONE_IRQ_ENABLE))
					prdata <= {30'h0000_0000, tone_irq_enable};
				else if (hit(paddr, `OFS_SYS_STATE))
					prdata <= {30'h0000_0000, debug_mode, sleep_mode};
			end
		end
	end
endmodule : buzzer_tone_generator

// ===== sim/buzzer_tone_assertions.sv
// Purpose: port checks for the buzzer tone generator
// Assumes: master holds each request until pready
// Notes:   bound from the bench top
`timescale 1ns/1ps
module buzzer_tone_assertions
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        sleep_mode,
	input wire logic        debug_mode,
	input wire logic        tone_out,
	input wire logic        tone_out_n
);
	default clocking dc @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence setup_s;
		psel && !penable;
	endsequence
	ready_after_setup_a: assert property (setup_s |=> pready && penable)
		else $error("no pready after setup");
	ready_in_access_a: assert property (pready |-> psel && penable && $past(psel))
		else $error("pready outside access");
	ready_one_cycle_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	error_decode_a: assert property (pready |-> pslverr == (paddr[11:2] > 10'h006))
		else $error("pslverr does not match address");
	error_with_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	unmapped_read_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	pins_never_both_a: assert property (!(tone_out && tone_out_n))
		else $error("both buzzer pins high");
	reset_pins_low_a: assert property ($rose(presetn) |-> (!tone_out && !tone_out_n) [*3])
		else $error("buzzer pins not low after reset");
endmodule : buzzer_tone_assertions

// ===== sim/piezo_buzzer_model.sv
// Purpose: piezo across the two buzzer pins, measures the tone
// Assumes: pins registered on pclk
// Notes:   lengths in pclk cycles; inverted pin judged by the checker
`timescale 1ns/1ps
module piezo_buzzer_model
(
	input  wire logic pclk,
	input  wire logic tone_out,
	input  wire logic tone_out_n,
	output int        high_len,
	output int        period_len,
	output int        rises
);
	logic prev = 1'b0;
	int   since = 0;
	int   hc = 0;
	initial
	begin
		high_len = 0;
		period_len = 0;
		rises = 0;
	end
	always @(posedge pclk)
	begin
		prev <= tone_out;
		since <= (tone_out && !prev) ? 1 : since + 1;
		hc <= !tone_out ? 0 : (prev ? hc + 1 : 1);
		if (tone_out && !prev)
		begin
			period_len <= since;
			rises <= rises + 1;
		end
		if (!tone_out && prev)
			high_len <= hc;
	end
endmodule : piezo_buzzer_model

// ===== sim/buzzer_tone_generator_tb_top.sv
// Purpose: self-checking bench for the buzzer tone generator
// Assumes: tone divider set to 3, one tone tick every 4 pclk
// Notes:   tone lengths are (field + 1) * 4 pclk
`timescale 1ns/1ps
`include "buzzer_defines.svh"
module buzzer_tone_generator_tb_top;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        sleep_mode;
	logic        debug_mode;
	logic        tone_out;
	logic        tone_out_n;
	logic [31:0] rd_v;
	logic        rd_e;
	int          high_len;
	int          period_len;
	int          rises;
	int          r;
	int          n_mismatch = 0;
	int          checks = 0;
	buzzer_tone_generator i_buzzer_tone_generator (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode),
		.debug_mode(debug_mode), .tone_out(tone_out), .tone_out_n(tone_out_n));
	piezo_buzzer_model i_piezo_buzzer_model (.pclk(pclk), .tone_out(tone_out),
		.tone_out_n(tone_out_n), .high_len(high_len), .period_len(period_len), .rises(rises));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// no cycle limit here; the watchdog ends a hung transfer
		while (pready !== 1'b1)
			@(posedge pclk);
		rd_v = prdata;
		rd_e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0);
		check(what, rd_v, exp);
	endtask : rd
	task automatic t_regs;
		rd(`OFS_TONE_FLAGS, 32'h1, "flags_rst");
		rd(`OFS_TONE_CLOCK_CONFIG, 32'h0005f602, "clk_rst");
		rd(12'h01c, 32'h0, "unmapped");
		check("slverr", {31'h0, rd_e}, 32'h1);
		$display("test regs done");
	endtask : t_regs
	task automatic t_start;
		apb(1'b1, `OFS_TONE_CLOCK_CONFIG, 32'h302);
		apb(1'b1, `OFS_TONE_CONTROL, 32'h1);
		apb(1'b1, `OFS_TONE_SELECT, 32'h1);
		apb(1'b1, `OFS_TONE_FLAGS, 32'h2);
		debug_mode <= 1'b1;
		apb(1'b1, `OFS_SOUND_BUFFER, 32'h0207);
		rd(`OFS_TONE_FLAGS, 32'h0, "empty_clr");
		debug_mode <= 1'b0;
		repeat (10) @(posedge pclk);
		rd(`OFS_TONE_FLAGS, 32'h5, "loaded");
		repeat (100) @(posedge pclk);
		check("period", period_len, 32);
		check("high", high_len, 12);
		$display("test start done");
	endtask : t_start
	task automatic t_freeze;
		logic [1:0] pins;
		debug_mode <= 1'b1;
		repeat (2) @(posedge pclk);
		pins = {tone_out, tone_out_n};
		r = rises;
		repeat (64) @(posedge pclk);
		check("dbg_pins", {tone_out, tone_out_n}, pins);
		check("dbg_rise", rises, r);
		apb(1'b1, `OFS_TONE_CLOCK_CONFIG, 32'h303);
		r = rises;
		repeat (64) @(posedge pclk);
		check("dbg_run", rises > r, 1);
		debug_mode <= 1'b0;
		sleep_mode <= 1'b1;
		repeat (2) @(posedge pclk);
		r = rises;
		repeat (64) @(posedge pclk);
		check("slp_stop", rises, r);
		apb(1'b1, `OFS_TONE_CLOCK_CONFIG, 32'h301);
		r = rises;
		repeat (64) @(posedge pclk);
		check("slp_run", rises > r, 1);
		sleep_mode <= 1'b0;
		$display("test freeze done");
	endtask : t_freeze
	task automatic t_stop;
		apb(1'b1, `OFS_TONE_CONTROL, 32'h3);
		repeat (2) @(posedge pclk);
		check("off_norm", {tone_out, tone_out_n}, 2'b01);
		rd(`OFS_TONE_FLAGS, 32'h3, "stopped");
		apb(1'b1, `OFS_TONE_FLAGS, 32'h2);
		rd(`OFS_TONE_FLAGS, 32'h1, "done_clr");
		apb(1'b1, `OFS_TONE_SELECT, 32'h0);
		repeat (2) @(posedge pclk);
		check("off_dir", {tone_out, tone_out_n}, 2'b00);
		apb(1'b1, `OFS_SOUND_BUFFER, 32'h0003);
		repeat (18) @(posedge pclk);
		check("first_hi", high_len, 4);
		repeat (40) @(posedge pclk);
		check("period2", period_len, 16);
		$display("test stop done");
	endtask : t_stop
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	initial
	begin
		#400000;
		n_mismatch++;
		tally_and_finish;
	end
	initial
	begin
		{presetn, psel, penable, pwrite, sleep_mode, debug_mode} = 6'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_start;
		t_freeze;
		t_stop;
		tally_and_finish;
	end
endmodule : buzzer_tone_generator_tb_top
bind buzzer_tone_generator buzzer_tone_assertions i_buzzer_tone_assertions (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.sleep_mode(sleep_mode), .debug_mode(debug_mode), .tone_out(tone_out),
	.tone_out_n(tone_out_n));
